/* File: verilog/can_xcvr_pkg.sv */
// constants, register map and mode encodings for the bus transceiver control
package can_xcvr_pkg;
    typedef enum logic [1:0] {
        MODE_SLEEP_NOWAKE = 2'h0,
        MODE_LISTEN       = 2'h1,
        MODE_SLEEP_WAKE   = 2'h2,
        MODE_NORMAL       = 2'h3
    } xcvr_mode_t;

    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned SHORT_SAMPLE_NS = 500;
    // sample point is a least time: round up
    localparam int unsigned SHORT_SAMPLE_CYC = (SHORT_SAMPLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SHORT_REPEAT     = 5;
    localparam int unsigned RX_REC_REPEAT    = 7;
    localparam int unsigned TX_DOM_TIMEOUT_US  = 1000;
    localparam int unsigned BUS_DOM_TIMEOUT_US = 1000;
    localparam int unsigned TX_DOM_CYC  = TX_DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned BUS_DOM_CYC = BUS_DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);

    localparam logic [3:0] ADDR_MODE       = 4'h0;
    localparam logic [3:0] ADDR_BUS_DIAG   = 4'h1;
    localparam logic [3:0] ADDR_SHARED_DIAG = 4'h2;
    localparam logic [3:0] ADDR_IRQ_INHIBIT = 4'h3;

    // bus_diag_register bit positions
    localparam int unsigned BIT_TX_DOM   = 0;
    localparam int unsigned BIT_RX_REC   = 1;
    localparam int unsigned BIT_BUS_DOM  = 2;
    localparam int unsigned BIT_LO_GND   = 3;
    localparam int unsigned BIT_HI_BATT  = 4;
    localparam int unsigned BIT_LO_BATT  = 5;
    localparam int unsigned BIT_HI_GND   = 6;
    localparam int unsigned BUS_DIAG_W   = 7;
    // shared_diag_register bit positions
    localparam int unsigned BIT_OT       = 0;
    localparam logic [7:0]  RESET_MODE   = 8'h03;
    localparam logic [7:0]  ZERO8        = 8'h00;
endpackage

/* File: verilog/short_qualifier_if.sv */
// carrier between the top and a short-circuit qualifier
interface short_qualifier_if;
    logic sample;
    logic comp;
    logic clear;
    logic detect;
    modport top  (output sample, output comp, output clear, input detect);
    modport qual (input sample, input comp, input clear, output detect);
endinterface

/* File: verilog/short_qualifier.sv */
// counts consecutive comparator hits at each sample point
module short_qualifier
    import can_xcvr_pkg::*;
#(
    parameter int unsigned REPEAT = SHORT_REPEAT
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    short_qualifier_if.qual  q
);
    logic [3:0] hits_ff;
    logic       detect_ff;

    always_ff @(posedge clk_sys) begin
        if (rst || q.clear) begin
            hits_ff <= 4'h0;
        end else if (q.sample) begin
            // a single miss breaks the run
            hits_ff <= q.comp ? ((hits_ff == 4'(REPEAT)) ? hits_ff : hits_ff + 4'h1) : 4'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            detect_ff <= 1'b0;
        end else begin
            detect_ff <= q.sample && q.comp && (hits_ff == 4'(REPEAT - 1));
        end
    end
    assign q.detect = detect_ff;
endmodule

/* File: verilog/can_transceiver_mode_fault_ctrl.sv */
// mode control and fault supervision of the bus transceiver
//
// Strobed register access and the register offsets were left to the implementer.
module can_transceiver_mode_fault_ctrl
    import can_xcvr_pkg::*;
#(
    parameter int unsigned TX_DOM_CYCLES  = TX_DOM_CYC,
    parameter int unsigned BUS_DOM_CYCLES = BUS_DOM_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       low_power_off_state,
    input  wire logic       txd,
    output logic            rxd,
    input  wire logic       bus_sense_dominant,
    output logic            bus_drive_en,
    output logic            receiver_en,
    input  wire logic       lo_low_comp,
    input  wire logic       hi_high_comp,
    input  wire logic       lo_overcurrent,
    input  wire logic       hi_overcurrent,
    input  wire logic       overtemp,
    input  wire logic       cooled_down,
    output logic            error_irq
);
    // ========================================================
    // mode field
    // ========================================================
    xcvr_mode_t mode_ff;
    xcvr_mode_t saved_mode_ff;
    logic       lowpow_d_ff;
    logic       tx_fault_ff, rx_fault_ff, ot_fault_ff;
    logic       tx_wait_high_ff, ot_rearm_ff;
    logic [BUS_DIAG_W-1:0] diag_ff;
    logic       ot_flag_ff;
    logic       inhibit_ff;
    logic       txd_d_ff;

    logic wr_mode, normal_written, lp_enter, lp_leave, active;
    logic tx_timeout, rx_stuck, bus_dom_timeout, ot_trip, tx_fall;
    assign wr_mode        = reg_wr && (reg_addr == ADDR_MODE);
    assign normal_written = wr_mode && (xcvr_mode_t'(reg_wdata[1:0]) == MODE_NORMAL);
    assign lp_enter       = low_power_off_state && !lowpow_d_ff;
    assign lp_leave       = !low_power_off_state && lowpow_d_ff;
    assign active = !low_power_off_state && ((mode_ff == MODE_NORMAL) || (mode_ff == MODE_LISTEN));
    assign tx_fall = txd_d_ff && !txd;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lowpow_d_ff <= 1'b0;
            txd_d_ff   <= 1'b1;
        end else begin
            lowpow_d_ff <= low_power_off_state;
            txd_d_ff   <= txd;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_ff       <= xcvr_mode_t'(RESET_MODE[1:0]);
            saved_mode_ff <= xcvr_mode_t'(RESET_MODE[1:0]);
        end else if (lp_enter) begin
            saved_mode_ff <= mode_ff;
            mode_ff <= (mode_ff == MODE_SLEEP_NOWAKE) ? MODE_SLEEP_NOWAKE : MODE_SLEEP_WAKE;
        end else if (lp_leave) begin
            mode_ff <= saved_mode_ff;
        end else if (tx_timeout || rx_stuck || ot_trip) begin
            mode_ff <= xcvr_mode_t'({1'b0, mode_ff[0]});
        end else if (wr_mode && !low_power_off_state) begin
            mode_ff <= xcvr_mode_t'(reg_wdata[1:0]);
        end
    end

    // ========================================================
    // transmit stuck dominant
    // ========================================================
    logic [$clog2(TX_DOM_CYCLES+1)-1:0] tx_cnt_ff;
    always_ff @(posedge clk_sys) begin
        if (rst || !active || txd) begin
            tx_cnt_ff <= '0;
        end else if (tx_cnt_ff != ($bits(tx_cnt_ff))'(TX_DOM_CYCLES)) begin
            tx_cnt_ff <= tx_cnt_ff + 1'b1;
        end
    end
    assign tx_timeout = active && !txd && !tx_fault_ff &&
                        (tx_cnt_ff == ($bits(tx_cnt_ff))'(TX_DOM_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_fault_ff     <= 1'b0;
            tx_wait_high_ff <= 1'b0;
        end else if (tx_timeout) begin
            tx_fault_ff     <= 1'b1;
            tx_wait_high_ff <= 1'b0;
        end else if (tx_fault_ff) begin
            // the rewrite must come first, then a high sample
            if (normal_written) begin
                tx_wait_high_ff <= 1'b1;
            end else if (tx_wait_high_ff && txd && mode_ff == MODE_NORMAL) begin
                tx_fault_ff     <= 1'b0;
                tx_wait_high_ff <= 1'b0;
            end
        end
    end

    // ========================================================
    // receive stuck recessive: bus should be dominant, receive high
    // ========================================================
    logic [2:0] rx_cnt_ff;
    logic       expect_dom;
    assign expect_dom = active && bus_drive_en && !txd;
    always_ff @(posedge clk_sys) begin
        if (rst || !active) begin
            rx_cnt_ff <= 3'h0;
        end else if (expect_dom) begin
            rx_cnt_ff <= rxd ? ((rx_cnt_ff == 3'(RX_REC_REPEAT)) ? rx_cnt_ff : rx_cnt_ff + 3'h1) : 3'h0;
        end
    end
    assign rx_stuck = expect_dom && rxd && !rx_fault_ff && (rx_cnt_ff == 3'(RX_REC_REPEAT - 1));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_fault_ff <= 1'b0;
        end else if (rx_stuck) begin
            rx_fault_ff <= 1'b1;
        end else if (normal_written) begin
            rx_fault_ff <= 1'b0;
        end
    end

    // ========================================================
    // bus dominant timeout
    // ========================================================
    logic [$clog2(BUS_DOM_CYCLES+1)-1:0] bus_cnt_ff;
    always_ff @(posedge clk_sys) begin
        if (rst || !active || !bus_sense_dominant) begin
            bus_cnt_ff <= '0;
        end else if (bus_cnt_ff != ($bits(bus_cnt_ff))'(BUS_DOM_CYCLES)) begin
            bus_cnt_ff <= bus_cnt_ff + 1'b1;
        end
    end
    // flag only, drivers untouched
    assign bus_dom_timeout = active && bus_sense_dominant &&
                             (bus_cnt_ff == ($bits(bus_cnt_ff))'(BUS_DOM_CYCLES - 1));

    // ========================================================
    // overtemperature
    // ========================================================
    assign ot_trip = overtemp && !ot_fault_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ot_fault_ff <= 1'b0;
            ot_rearm_ff <= 1'b0;
        end else if (ot_trip) begin
            ot_fault_ff <= 1'b1;
            ot_rearm_ff <= 1'b0;
        end else if (ot_fault_ff) begin
            if (normal_written) begin
                ot_rearm_ff <= 1'b1;
            end
            // falling edge while hot is ignored
            if (ot_rearm_ff && cooled_down && !overtemp && tx_fall && mode_ff == MODE_NORMAL) begin
                ot_fault_ff <= 1'b0;
                ot_rearm_ff <= 1'b0;
            end
        end
    end

    // ========================================================
    // short-circuit qualification, reported only
    // ========================================================
    logic [$clog2(SHORT_SAMPLE_CYC+1)-1:0] smp_cnt_ff;
    logic smp_run_ff, sample_pt;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            smp_run_ff <= 1'b0;
            smp_cnt_ff <= '0;
        end else if (tx_fall) begin
            smp_run_ff <= 1'b1;
            smp_cnt_ff <= '0;
        end else if (smp_run_ff) begin
            smp_cnt_ff <= smp_cnt_ff + 1'b1;
            smp_run_ff <= !sample_pt;
        end
    end
    assign sample_pt = smp_run_ff && (smp_cnt_ff == ($bits(smp_cnt_ff))'(SHORT_SAMPLE_CYC - 1));

    short_qualifier_if sq [4] ();
    logic [3:0] comps, shorts;
    assign comps = {hi_overcurrent, lo_overcurrent, hi_high_comp, lo_low_comp};
    for (genvar i = 0; i < 4; i++) begin : g_short
        assign sq[i].sample = sample_pt;
        assign sq[i].comp   = comps[i];
        assign sq[i].clear  = !active;
        assign shorts[i]    = sq[i].detect;
        short_qualifier #(.REPEAT(SHORT_REPEAT)) u_q (
            .clk_sys (clk_sys),
            .rst     (rst),
            .q       (sq[i].qual)
        );
    end

    // ========================================================
    // sticky flags: hardware set wins over software clear
    // ========================================================
    logic [BUS_DIAG_W-1:0] diag_set;
    logic                  clr_diag, clr_ot;
    always_comb begin
        diag_set = '0;
        diag_set[BIT_TX_DOM]  = tx_timeout;
        diag_set[BIT_RX_REC]  = rx_stuck;
        diag_set[BIT_BUS_DOM] = bus_dom_timeout;
        diag_set[BIT_LO_GND]  = shorts[0];
        diag_set[BIT_HI_BATT] = shorts[1];
        diag_set[BIT_LO_BATT] = shorts[2];
        diag_set[BIT_HI_GND]  = shorts[3];
    end
    assign clr_diag = reg_wr && (reg_addr == ADDR_BUS_DIAG);
    assign clr_ot   = reg_wr && (reg_addr == ADDR_SHARED_DIAG) && reg_wdata[BIT_OT];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            diag_ff <= '0;
        end else begin
            // write one to clear
            diag_ff <= (diag_ff & ~(clr_diag ? reg_wdata[BUS_DIAG_W-1:0] : '0)) | diag_set;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ot_flag_ff <= 1'b0;
        end else begin
            ot_flag_ff <= ot_trip || (ot_flag_ff && !clr_ot);
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            inhibit_ff <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_IRQ_INHIBIT) begin
            inhibit_ff <= reg_wdata[0];
        end
    end
    // shorts are information only and stay off the interrupt
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            error_irq <= 1'b0;
        end else begin
            error_irq <= !inhibit_ff && (diag_ff[BIT_TX_DOM] || diag_ff[BIT_RX_REC] ||
                                         diag_ff[BIT_BUS_DOM] || ot_flag_ff);
        end
    end

    // ========================================================
    // pin drive
    // ========================================================
    logic drv_ok, rcv_ok;
    assign drv_ok = !low_power_off_state && mode_ff == MODE_NORMAL &&
                    !tx_fault_ff && !rx_fault_ff && !ot_fault_ff && !tx_timeout && !rx_stuck && !ot_trip;
    assign rcv_ok = !low_power_off_state && (mode_ff == MODE_NORMAL || mode_ff == MODE_LISTEN) &&
                    !rx_fault_ff && !rx_stuck;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_drive_en <= 1'b0;
            receiver_en  <= 1'b0;
            rxd          <= 1'b0;
        end else begin
            bus_drive_en <= drv_ok && !txd;
            receiver_en  <= rcv_ok;
            rxd          <= rcv_ok ? !bus_sense_dominant : 1'b0;
        end
    end

    // ========================================================
    // register read, one cycle later
    // ========================================================
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= ZERO8;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_MODE:        reg_rdata <= {6'h00, mode_ff};
                ADDR_BUS_DIAG:    reg_rdata <= {1'b0, diag_ff};
                ADDR_SHARED_DIAG: reg_rdata <= {7'h00, ot_flag_ff};
                ADDR_IRQ_INHIBIT: reg_rdata <= {7'h00, inhibit_ff};
                default:          reg_rdata <= ZERO8;
            endcase
        end else begin
            reg_rdata <= ZERO8;
        end
    end
endmodule

/* File: dv/can_xcvr_checker.sv */
// port-level assertions for the transceiver mode and fault control
module can_xcvr_checker
    import can_xcvr_pkg::*;
#(
    parameter int unsigned TX_DOM_CYCLES = TX_DOM_CYC
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       low_power_off_state,
    input wire logic       txd,
    input wire logic       rxd,
    input wire logic       bus_sense_dominant,
    input wire logic       bus_drive_en,
    input wire logic       receiver_en,
    input wire logic       error_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ====================
    // run counters: long holds are checked on a counter, not by repetition
    logic [15:0] drive_run_ff;
    logic [3:0]  rx_run_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) drive_run_ff <= 16'h0000;
        else drive_run_ff <= bus_drive_en ? drive_run_ff + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_sys) begin
        if (rst) rx_run_ff <= 4'h0;
        else rx_run_ff <= (bus_drive_en && !txd && rxd) ? rx_run_ff + 4'h1 : 4'h0;
    end
    // ====================
    // assertions
    a_drive_follows_txd: assert property (
        bus_drive_en |-> !$past(txd)) else $error("drivers on without low transmit data");
    a_low_power_off_state_all_off: assert property (
        $past(low_power_off_state) |-> !bus_drive_en && !receiver_en && !rxd) else $error("active in low power");
    a_rx_follows_bus: assert property (
        receiver_en && $past(receiver_en) |-> rxd == !$past(bus_sense_dominant)) else $error("receive not bus level");
    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == ZERO8) else $error("read data outside read slot");
    a_mode_read_width: assert property (
        $past(reg_rd) && $past(reg_addr) == ADDR_MODE |-> reg_rdata[7:2] == 6'h00) else $error("mode read too wide");
    a_tx_timeout_bound: assert property (
        drive_run_ff <= TX_DOM_CYCLES + 2) else $error("drivers on past transmit timeout");
    a_rx_stuck_bound: assert property (
        rx_run_ff <= 4'h9) else $error("stuck recessive receive not caught");
    a_listen_no_drive: assert property (
        $past(reg_wr) && $past(reg_addr) == ADDR_MODE && $past(reg_wdata[1:0]) == MODE_LISTEN
        && !$past(low_power_off_state) |-> ##1 !bus_drive_en) else $error("drivers on in listen mode");
    c_drive_on: cover property (bus_drive_en);
    c_irq_rise: cover property ($rose(error_irq));
    c_rx_cut: cover property ($fell(receiver_en) && !low_power_off_state);
endmodule

bind can_transceiver_mode_fault_ctrl can_xcvr_checker #(.TX_DOM_CYCLES(TX_DOM_CYCLES)) can_xcvr_checker_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_power_off_state(low_power_off_state), .txd(txd),
    .rxd(rxd), .bus_sense_dominant(bus_sense_dominant), .bus_drive_en(bus_drive_en),
    .receiver_en(receiver_en), .error_irq(error_irq));

/* File: dv/can_ctrl_model.sv */
// model of the host protocol controller that drives transmit data
module can_ctrl_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        stuck_low,
    input  wire logic [15:0] frame,
    output logic             txd,
    output logic             busy
);
    // ====================
    // frame shifter, four clocks per bit
    logic [5:0]  cnt_ff;
    logic [15:0] shift_ff;
    logic        bit_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff   <= 6'h00;
            shift_ff <= 16'hffff;
            bit_ff   <= 1'b1;
        end else if (start && cnt_ff == 6'h00) begin
            cnt_ff   <= 6'h3f;
            shift_ff <= frame;
        end else if (cnt_ff != 6'h00) begin
            cnt_ff <= cnt_ff - 6'h01;
            if (cnt_ff[1:0] == 2'h3) begin
                bit_ff   <= shift_ff[15];
                shift_ff <= {shift_ff[14:0], 1'b1};
            end
        end else begin
            bit_ff <= 1'b1; // idle high so a fault recovery can see a high level
        end
    end
    // stuck_low is the controller fault that a scenario commands
    assign txd  = bit_ff & ~stuck_low;
    assign busy = (cnt_ff != 6'h00);
endmodule

/* File: dv/can_transceiver_mode_fault_ctrl_tb.sv */
// self-checking bench for the transceiver mode and fault control
module can_transceiver_mode_fault_ctrl_tb
    import can_xcvr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TXC  = 20;
    localparam int BUSC = 40;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        lp_off = 1'b0;
    logic        other_dom = 1'b0;
    logic        rx_open = 1'b0;
    logic [3:0]  sc = 4'h0;
    logic        overtemp = 1'b0;
    logic        cooled_down = 1'b1;
    logic        start = 1'b0;
    logic        stuck_low = 1'b0;
    logic [15:0] frame = 16'hffff;
    logic [7:0]  reg_rdata;
    logic        txd, rxd, busy, bus_drive_en, receiver_en, error_irq;
    logic        bus_sense_dominant;
    logic [1:0]  m;
    integer      seed = 32'h686c;
    int          errors = 0;
    int          total_checks = 0;
    int          i, j, n;
    always #20 clk_sys = ~clk_sys;
    // an open receive path hides our own dominant drive from the sensed level
    assign bus_sense_dominant = (bus_drive_en & ~rx_open) | other_dom;
    can_ctrl_model can_ctrl_model_i (.clk_sys(clk_sys), .rst(rst), .start(start), .stuck_low(stuck_low),
        .frame(frame), .txd(txd), .busy(busy));
    can_transceiver_mode_fault_ctrl #(.TX_DOM_CYCLES(TXC), .BUS_DOM_CYCLES(BUSC)) can_transceiver_mode_fault_ctrl_i (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_power_off_state(lp_off), .txd(txd), .rxd(rxd),
        .bus_sense_dominant(bus_sense_dominant), .bus_drive_en(bus_drive_en), .receiver_en(receiver_en),
        .lo_low_comp(sc[0]), .hi_high_comp(sc[1]), .lo_overcurrent(sc[2]), .hi_overcurrent(sc[3]),
        .overtemp(overtemp), .cooled_down(cooled_down), .error_irq(error_irq));
    // ====================
    // checks and bus tasks
    task automatic report_and_stop;
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys) begin reg_addr <= a; reg_rd <= 1'b1; end
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic pulse(input int cyc, input logic e);
        @(posedge clk_sys) stuck_low <= 1'b1;
        repeat (cyc) @(posedge clk_sys);
        #1 chk(8'(bus_drive_en), 8'(e));
        @(posedge clk_sys) stuck_low <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    function automatic logic [1:0] exp_sleep(input logic [1:0] md);
        return (md == MODE_SLEEP_NOWAKE) ? MODE_SLEEP_NOWAKE : MODE_SLEEP_WAKE;
    endfunction
    function automatic logic [7:0] exp_short(input int k);
        return 8'h01 << (BIT_LO_GND + k);
    endfunction
    task automatic hold_dom(input int cyc);
        @(posedge clk_sys) other_dom <= 1'b1;
        repeat (cyc) @(posedge clk_sys);
        @(posedge clk_sys) other_dom <= 1'b0;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        report_and_stop();
    end
    // ====================
    // scenarios
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ADDR_MODE, RESET_MODE);
        rd(4'h4, ZERO8);
        for (i = 0; i < 3; i++) begin
            @(posedge clk_sys) begin frame <= 16'($random(seed)) | 16'h8888; start <= 1'b1; end
            @(posedge clk_sys) start <= 1'b0;
            #1;
            for (n = 0; n < 100 && busy; n++) @(posedge clk_sys);
            if (busy) begin errors++; report_and_stop(); end
        end
        rd(ADDR_BUS_DIAG, ZERO8);
        m = 2'($random(seed));
        for (i = 0; i < 4; i++) begin
            wr(ADDR_MODE, {6'h00, m});
            rd(ADDR_MODE, {6'h00, m});
            pulse(3, m == MODE_NORMAL);
            m = m + 2'h1;
        end
        for (i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(ADDR_MODE, {6'h00, m});
            @(posedge clk_sys) lp_off <= 1'b1;
            repeat (3) @(posedge clk_sys);
            rd(ADDR_MODE, {6'h00, exp_sleep(m)});
            chk(8'(bus_drive_en | receiver_en | rxd), ZERO8);
            wr(ADDR_MODE, 8'h03);
            rd(ADDR_MODE, {6'h00, exp_sleep(m)});
            @(posedge clk_sys) lp_off <= 1'b0;
            repeat (3) @(posedge clk_sys);
            rd(ADDR_MODE, {6'h00, m});
        end
        @(posedge clk_sys) stuck_low <= 1'b1;
        repeat (TXC + 4) @(posedge clk_sys);
        #1 chk(8'(bus_drive_en), 8'h00);
        chk(8'(receiver_en), 8'h01);
        chk(8'(error_irq), 8'h01);
        rd(ADDR_MODE, 8'h01);
        @(posedge clk_sys) stuck_low <= 1'b0;
        wr(ADDR_MODE, 8'h03);
        repeat (2) @(posedge clk_sys);
        pulse(3, 1'b1);
        rd(ADDR_BUS_DIAG, 8'h01);
        wr(ADDR_BUS_DIAG, 8'h01);
        rd(ADDR_BUS_DIAG, ZERO8);
        @(posedge clk_sys) begin rx_open <= 1'b1; stuck_low <= 1'b1; end
        repeat (12) @(posedge clk_sys);
        #1 chk(8'(receiver_en | bus_drive_en), 8'h00);
        @(posedge clk_sys) begin rx_open <= 1'b0; stuck_low <= 1'b0; end
        rd(ADDR_MODE, 8'h01);
        rd(ADDR_BUS_DIAG, 8'h02);
        wr(ADDR_MODE, 8'h03);
        repeat (2) @(posedge clk_sys);
        #1 chk(8'(receiver_en), 8'h01);
        wr(ADDR_BUS_DIAG, 8'h02);
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys) sc <= 4'h1 << i;
            for (j = 0; j < 5; j++) begin
                if (j == 4) rd(ADDR_BUS_DIAG, ZERO8);
                pulse(14, 1'b1);
            end
            rd(ADDR_BUS_DIAG, exp_short(i));
            chk(8'(error_irq), 8'h00);
            chk(8'(receiver_en), 8'h01);
            wr(ADDR_BUS_DIAG, exp_short(i));
            @(posedge clk_sys) sc <= 4'h0;
        end
        hold_dom(BUSC + 4);
        rd(ADDR_BUS_DIAG, 8'h04);
        rd(ADDR_MODE, 8'h03);
        chk(8'(error_irq), 8'h01);
        wr(ADDR_IRQ_INHIBIT, 8'h01);
        repeat (2) @(posedge clk_sys);
        #1 chk(8'(error_irq), 8'h00);
        wr(ADDR_IRQ_INHIBIT, 8'h00);
        wr(ADDR_BUS_DIAG, 8'h04);
        rd(ADDR_BUS_DIAG, ZERO8);
        wr(ADDR_MODE, 8'h02);
        hold_dom(BUSC + 4);
        rd(ADDR_BUS_DIAG, ZERO8);
        wr(ADDR_MODE, 8'h03);
        @(posedge clk_sys) begin overtemp <= 1'b1; cooled_down <= 1'b0; end
        @(posedge clk_sys) overtemp <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk(8'(receiver_en), 8'h01);
        rd(ADDR_SHARED_DIAG, 8'h01);
        rd(ADDR_MODE, 8'h01);
        wr(ADDR_MODE, 8'h03);
        pulse(3, 1'b0);
        @(posedge clk_sys) cooled_down <= 1'b1;
        pulse(3, 1'b1);
        wr(ADDR_SHARED_DIAG, 8'h01);
        rd(ADDR_SHARED_DIAG, ZERO8);
        report_and_stop();
    end
endmodule
